// file: sst_defs.svh
`ifndef SST_DEFS_SVH
`define SST_DEFS_SVH

// ------------------------------------------------------------------
// Register word indices; byte address is four times the index.
// ------------------------------------------------------------------
`define IDX_INTERRUPT_CONTROL 4'h0
`define IDX_PERIPHERAL_FLAGS_ONE 4'h1
`define IDX_PERIPHERAL_ENABLES_ONE 4'h2
`define IDX_PERIPHERAL_PRIORITIES_ONE 4'h3
`define IDX_RECEIVE_STATUS_CONTROL 4'h4
`define IDX_TRANSMIT_HOLDING 4'h5
`define IDX_TRANSMIT_STATUS_CONTROL 4'h6
`define IDX_BAUD_CONTROL 4'h7
`define IDX_BAUD_DIVISOR_HIGH 4'h8
`define IDX_BAUD_DIVISOR_LOW 4'h9

// ------------------------------------------------------------------
// Field positions.
// ------------------------------------------------------------------
`define TSC_CLOCK_SOURCE_SELECT 7
`define TSC_NINE_BIT_TRANSMIT_SELECT 6
`define TSC_TRANSMIT_ENABLE_BIT 5
`define TSC_SYNC_MODE 4
`define TSC_SHIFT_REGISTER_EMPTY 1
`define TSC_NINTH_TRANSMIT_BIT 0
`define RSC_SERIAL_PORT_ENABLE 7
`define RSC_SINGLE_RECEIVE_ENABLE 5
`define RSC_CONTINUOUS_RECEIVE_ENABLE 4
`define BC_CLOCK_POLARITY_INVERT 4
`define IC_GLOBAL_INTERRUPT_ENABLE 7
`define IC_PERIPHERAL_INTERRUPT_ENABLE 6
`define PF_TRANSMIT_INTERRUPT_FLAG 4
`define PE_TRANSMIT_INTERRUPT_ENABLE 4

// ------------------------------------------------------------------
// Reset values and character lengths.
// ------------------------------------------------------------------
`define RESET_BYTE 8'h00
`define CHAR_BITS_SHORT 4'h8
`define CHAR_BITS_LONG 4'h9

`endif

// file: sst_pkg.sv
package sst_pkg;

    typedef enum logic [1:0] {
        LINK_IDLE = 2'b01,
        LINK_SHIFT = 2'b10
    } link_mode_t;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic act_s1;
        logic act_s2;
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic ack;
        link_mode_t mode;
        logic [8:0] shreg;
        logic [3:0] count;
        logic [3:0] last;
        logic data_out;
        logic data_oe_n;
    } link_state_t;

    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
        logic [7:0] interrupt_control;
        logic [7:0] peripheral_enables_one;
        logic [7:0] peripheral_priorities_one;
        logic [7:0] receive_status_control;
        logic [7:0] transmit_status_control;
        logic [7:0] baud_control;
        logic [7:0] baud_divisor_high;
        logic [7:0] baud_divisor_low;
        logic [7:0] hold;
        logic hold9;
        logic hold_full;
        logic [9:0] shift_word;
        logic req;
        logic ack_s1;
        logic ack_s2;
        logic active;
        logic flag;
        logic empty;
        logic wake;
        logic vector;
    } core_state_t;

endpackage : sst_pkg

// file: sst_link_shifter.sv
`timescale 1ns/1ps
`include "sst_defs.svh"

module sst_link_shifter (
    input wire logic link_clk,
    input wire logic rst,
    input wire logic active,
    input wire logic req_toggle,
    input wire logic [9:0] word,
    output logic ack_toggle,
    output logic data_out,
    output logic data_oe_n
);

    sst_pkg::link_state_t s;
    sst_pkg::link_state_t next_s;

    assign ack_toggle = s.ack;
    assign data_out = s.data_out;
    assign data_oe_n = s.data_oe_n;

    // ------------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.rst_s1 = rst;
        next_s.rst_s2 = s.rst_s1;
        next_s.act_s1 = active;
        next_s.act_s2 = s.act_s1;
        next_s.req_s1 = req_toggle;
        next_s.req_s2 = s.req_s1;
        if (s.rst_s2) begin
            next_s.mode = sst_pkg::LINK_IDLE;
            next_s.req_seen = 1'b0;
            next_s.ack = 1'b0;
            next_s.data_out = 1'b1;
            next_s.data_oe_n = 1'b1;
        end else if (!s.act_s2) begin
            // An aborted word is still acknowledged so the core never hangs.
            next_s.mode = sst_pkg::LINK_IDLE;
            next_s.ack = s.req_seen;
            next_s.data_out = 1'b1;
            next_s.data_oe_n = 1'b1;
        end else begin
            next_s.data_oe_n = 1'b0;
            unique case (s.mode)
                sst_pkg::LINK_IDLE: begin
                    next_s.data_out = 1'b1;
                    if (s.req_s2 != s.req_seen) begin
                        next_s.req_seen = s.req_s2;
                        next_s.data_out = word[0]; // R18
                        next_s.shreg = {1'b0, word[8:1]};
                        next_s.count = 4'h1;
                        next_s.last = word[9] ? `CHAR_BITS_LONG
                                              : `CHAR_BITS_SHORT; // R14
                        next_s.mode = sst_pkg::LINK_SHIFT;
                    end
                end
                sst_pkg::LINK_SHIFT: begin
                    if (s.count == s.last) begin
                        next_s.mode = sst_pkg::LINK_IDLE;
                        next_s.ack = s.req_seen; // R08
                        next_s.data_out = 1'b1;
                    end else begin
                        next_s.data_out = s.shreg[0]; // R18
                        next_s.shreg = {1'b0, s.shreg[8:1]};
                        next_s.count = s.count + 4'h1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register, clocked only by the external master.
    // ------------------------------------------------------------------
    always_ff @(posedge link_clk) begin // R02
        s <= next_s;
    end

endmodule : sst_link_shifter

// file: sync_slave_serial_tx.sv
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "sst_defs.svh"

// Behaviour
// R01: Clear clock source select gives slave mode.
// R02: Shift clock comes only from the pin.
// R03: Transmission continues in any low-power state.
// R04: Slave transmit matches master except sleep.
// R05: First word moves into shifter at once.
// R06: Second word waits while shifter busy.
// R07: Flag stays clear while holding word waits.
// R08: Shifter done, second word moves, flag sets.
// R09: Flag with enable wakes from sleep.
// R10: Global enable also requests interrupt vector.
// R11: Software sets sync, port enable, clears source.
// R12: Software clears both receive enables first.
// R13: Polarity invert bit inverts clock pin sense.
// R14: Nine-bit select makes nine-bit characters.
// R15: Software loads ninth bit before data.
// R16: Transmit enable on, then holding write starts.
// R17: Software sets global and peripheral enables.
// R18: One bit per clock, LSB first, empty flag.
module sync_slave_serial_tx (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sleep_mode,
    input wire logic shift_clock_pin,
    output logic data_pin_out,
    output logic data_pin_oe_n,
    output logic shift_register_empty,
    output logic wake_request,
    output logic interrupt_vector_request
);

    sst_pkg::core_state_t s;
    sst_pkg::core_state_t next_s;
    logic link_clk;
    logic ack_toggle;
    logic link_data;
    logic link_oe_n;

    // ------------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------------
    function automatic sst_pkg::core_state_t core_reset();
        sst_pkg::core_state_t r;
        r = '0;
        r.waitrequest = 1'b1;
        r.interrupt_control = `RESET_BYTE;
        r.peripheral_enables_one = `RESET_BYTE;
        r.peripheral_priorities_one = `RESET_BYTE;
        r.receive_status_control = `RESET_BYTE;
        r.transmit_status_control = `RESET_BYTE;
        r.baud_control = `RESET_BYTE;
        r.baud_divisor_high = `RESET_BYTE;
        r.baud_divisor_low = `RESET_BYTE;
        r.flag = 1'b1;
        r.empty = 1'b1;
        return r;
    endfunction : core_reset

    function automatic logic [7:0] read_byte(
        input sst_pkg::core_state_t st,
        input logic [3:0] idx
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            `IDX_INTERRUPT_CONTROL: v = st.interrupt_control;
            `IDX_PERIPHERAL_FLAGS_ONE: v[`PF_TRANSMIT_INTERRUPT_FLAG] = st.flag;
            `IDX_PERIPHERAL_ENABLES_ONE: v = st.peripheral_enables_one;
            `IDX_PERIPHERAL_PRIORITIES_ONE: v = st.peripheral_priorities_one;
            `IDX_RECEIVE_STATUS_CONTROL: v = st.receive_status_control;
            `IDX_TRANSMIT_STATUS_CONTROL: begin
                v = st.transmit_status_control;
                v[`TSC_SHIFT_REGISTER_EMPTY] = st.empty; // R18
            end
            `IDX_BAUD_CONTROL: v = st.baud_control;
            `IDX_BAUD_DIVISOR_HIGH: v = st.baud_divisor_high;
            `IDX_BAUD_DIVISOR_LOW: v = st.baud_divisor_low;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_byte

    // ------------------------------------------------------------------
    // Link clock.
    // ------------------------------------------------------------------
    // Data changes on the falling pin edge, or the rising one when
    // inverted. The invert bit steers a clock, so change it only while
    // the port is disabled.
    assign link_clk = shift_clock_pin
                      ~^ s.baud_control[`BC_CLOCK_POLARITY_INVERT]; // R13

    sst_link_shifter u_shifter (
        .link_clk(link_clk),
        .rst(rst),
        .active(s.active),
        .req_toggle(s.req),
        .word(s.shift_word),
        .ack_toggle(ack_toggle),
        .data_out(link_data),
        .data_oe_n(link_oe_n)
    );

    assign avs_readdata = s.readdata;
    assign avs_waitrequest = s.waitrequest;
    assign data_pin_out = link_data;
    assign data_pin_oe_n = link_oe_n;
    assign shift_register_empty = s.empty;
    assign wake_request = s.wake;
    assign interrupt_vector_request = s.vector;

    // ------------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------------
    always_comb begin
        logic [3:0] idx;
        logic [7:0] wbyte;
        logic enabled;
        logic busy;
        logic take;
        logic tx_ie;
        idx = avs_address[5:2];
        wbyte = avs_writedata[7:0];
        next_s = s;
        next_s.ack_s1 = ack_toggle;
        next_s.ack_s2 = s.ack_s1;

        // Slave mode only; the receive enables are left to software.
        enabled = s.receive_status_control[`RSC_SERIAL_PORT_ENABLE]
                  && s.transmit_status_control[`TSC_SYNC_MODE]
                  && !s.transmit_status_control[`TSC_CLOCK_SOURCE_SELECT]
                  && s.transmit_status_control[`TSC_TRANSMIT_ENABLE_BIT]; // R01
        next_s.active = enabled; // R16
        busy = s.req != s.ack_s2;
        // Sleep does not enter here: the shifter needs no core action.
        take = s.hold_full && !busy && enabled; // R03 R04
        if (take) begin
            next_s.shift_word = {
                s.transmit_status_control[`TSC_NINE_BIT_TRANSMIT_SELECT],
                s.hold9, s.hold}; // R05
            next_s.req = ~s.req;
            next_s.hold_full = 1'b0; // R06
        end

        // Bus: one wait cycle, then the access completes.
        if (s.waitrequest) begin
            if (avs_read || avs_write) begin
                next_s.waitrequest = 1'b0;
                next_s.readdata = avs_read ? {24'h000000, read_byte(s, idx)}
                                           : 32'h00000000;
            end
        end else begin
            next_s.waitrequest = 1'b1;
            next_s.readdata = 32'h00000000;
            if (avs_write && avs_byteenable[0]) begin
                unique case (idx)
                    `IDX_INTERRUPT_CONTROL: next_s.interrupt_control = wbyte;
                    `IDX_PERIPHERAL_ENABLES_ONE:
                        next_s.peripheral_enables_one = wbyte;
                    `IDX_PERIPHERAL_PRIORITIES_ONE:
                        next_s.peripheral_priorities_one = wbyte;
                    `IDX_RECEIVE_STATUS_CONTROL:
                        next_s.receive_status_control = wbyte;
                    `IDX_TRANSMIT_HOLDING: begin
                        // A write over a waiting word replaces it.
                        next_s.hold = wbyte; // R16
                        next_s.hold9 = s.transmit_status_control
                                       [`TSC_NINTH_TRANSMIT_BIT]; // R14
                        next_s.hold_full = 1'b1;
                    end
                    `IDX_TRANSMIT_STATUS_CONTROL:
                        next_s.transmit_status_control = wbyte;
                    `IDX_BAUD_CONTROL: next_s.baud_control = wbyte;
                    `IDX_BAUD_DIVISOR_HIGH: next_s.baud_divisor_high = wbyte;
                    `IDX_BAUD_DIVISOR_LOW: next_s.baud_divisor_low = wbyte;
                    default: next_s.hold_full = next_s.hold_full;
                endcase
            end
        end

        // The flag mirrors an empty holding register, so it only rises
        // when the waiting word has moved into the shifter.
        next_s.flag = !next_s.hold_full; // R07
        // Only the second synchroniser stage may be read here.
        next_s.empty = (next_s.req == s.ack_s2) && !next_s.hold_full;
        tx_ie = next_s.peripheral_enables_one[`PE_TRANSMIT_INTERRUPT_ENABLE];
        next_s.wake = sleep_mode && next_s.flag && tx_ie; // R09
        next_s.vector = next_s.flag && tx_ie
            && next_s.interrupt_control[`IC_PERIPHERAL_INTERRUPT_ENABLE]
            && next_s.interrupt_control[`IC_GLOBAL_INTERRUPT_ENABLE]; // R10
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s <= core_reset();
        end else begin
            s <= next_s;
        end
    end

endmodule : sync_slave_serial_tx

// file: sst_tx_props.sv
`timescale 1ns/1ps
// ----
// Port checker for the slave transmitter.
// ----
module sst_tx_props (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic sleep_mode,
    input wire logic shift_clock_pin,
    input wire logic data_pin_out,
    input wire logic data_pin_oe_n,
    input wire logic shift_register_empty,
    input wire logic wake_request,
    input wire logic interrupt_vector_request
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    bus_answer_a: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("Bus request not answered.");
    wait_once_a: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("Answer held too long.");
    rdata_idle_a: assert property (
        avs_waitrequest |-> avs_readdata == 32'h00000000)
        else $error("Read data outside answer.");
    wake_sleep_a: assert property (
        wake_request |-> $past(sleep_mode))
        else $error("Wake without sleep.");
    clock_pin_a: assert property (
        $changed(data_pin_out) |-> $changed(shift_clock_pin))
        else $error("Line moved without pin clock.");
    empty_fall_a: assert property (
        $fell(shift_register_empty) |-> $past(avs_write) ||
        $past(avs_write, 2))
        else $error("Empty fell without write.");
    idle_high_a: assert property (
        shift_register_empty |-> data_pin_out)
        else $error("Line low while empty.");
    oe_idle_a: assert property (
        data_pin_oe_n |-> data_pin_out)
        else $error("Line low while released.");
endmodule : sst_tx_props

// file: sst_sync_master.sv
`timescale 1ns/1ps
// ----
// External master that makes the shift clock and reads the line.
// ----
module sst_sync_master (
    input wire logic run,
    input wire logic invert,
    input wire logic nine,
    input wire logic data_pin_out,
    input wire logic data_pin_oe_n,
    output logic shift_clock_pin,
    output logic [8:0] last_word,
    output int words
);
    logic raw = 1'b1;
    logic busy = 1'b0;
    logic [8:0] acc = 9'h000;
    int cnt = 0;
    // The clock keeps running between frames, so a frame starts on the first 0 on the line.
    assign shift_clock_pin = raw ^ invert;
    initial begin
        #7;
        forever begin
            #24;
            raw = run ? ~raw : 1'b1;
        end
    end
    always @(posedge raw) begin
        if (!data_pin_oe_n && (busy || data_pin_out === 1'b0)) begin
            acc[cnt] = data_pin_out;
            cnt++;
            busy = 1'b1;
            if (cnt == (nine ? 9 : 8)) begin
                last_word = acc;
                words++;
                busy = 1'b0;
                cnt = 0;
            end
        end
    end
endmodule : sst_sync_master

// file: tb_sync_slave_serial_tx.sv
`timescale 1ns/1ps
`include "sst_defs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
    fail_count++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_sync_slave_serial_tx;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hf;
    logic sleep_mode = 1'b0;
    logic run = 1'b1;
    logic invert = 1'b0;
    logic nine = 1'b0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, shift_clock_pin, data_pin_out, data_pin_oe_n;
    logic shift_register_empty, wake_request, interrupt_vector_request;
    logic [8:0] last_word;
    int words;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    sync_slave_serial_tx i_dut (.core_clk, .rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .sleep_mode, .shift_clock_pin, .data_pin_out,
        .data_pin_oe_n, .shift_register_empty, .wake_request,
        .interrupt_vector_request);
    sst_sync_master i_master (.run, .invert, .nine, .data_pin_out,
        .data_pin_oe_n, .shift_clock_pin, .last_word, .words);
    initial forever #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end
    // ----
    // Bus and wait helpers.
    // ----
    task automatic conclude();
        if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic xfer(input logic wr, input logic [3:0] idx,
            input logic [7:0] wd, input logic [3:0] be,
            output logic [7:0] rd);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, wd};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge core_clk);
        end
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask : xfer
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [7:0] x;
        xfer(1'b1, idx, d, 4'hf, x);
    endtask : wr
    task automatic rd_chk(input logic [3:0] idx, input logic [7:0] e);
        logic [7:0] x;
        xfer(1'b0, idx, 8'h00, 4'hf, x);
        `CHK(x, e)
    endtask : rd_chk
    task automatic wait_hi(ref logic s);
        int k;
        k = 0;
        while (s !== 1'b1 && k < 300) begin
            @(posedge core_clk);
            k++;
        end
    endtask : wait_hi
    task automatic wait_words(input int n);
        int k;
        k = 0;
        while (words < n && k < 3000) begin
            @(posedge core_clk);
            k++;
        end
        `CHK(words, n)
    endtask : wait_words
    // ----
    // Scenarios.
    // ----
    task automatic t_regs();
        logic [7:0] x;
        rd_chk(`IDX_TRANSMIT_STATUS_CONTROL, 8'h02);
        wr(`IDX_PERIPHERAL_FLAGS_ONE, 8'hef);
        rd_chk(`IDX_PERIPHERAL_FLAGS_ONE, 8'h10);
        wr(`IDX_PERIPHERAL_PRIORITIES_ONE, 8'ha5);
        xfer(1'b1, `IDX_PERIPHERAL_PRIORITIES_ONE, 8'h3c, 4'he, x);
        rd_chk(`IDX_PERIPHERAL_PRIORITIES_ONE, 8'ha5);
        wr(4'hc, 8'h77);
        rd_chk(4'hc, 8'h00);
        rd_chk(`IDX_TRANSMIT_HOLDING, 8'h00);
    endtask : t_regs
    task automatic t_single();
        wr(`IDX_RECEIVE_STATUS_CONTROL, 8'h80);
        wr(`IDX_PERIPHERAL_ENABLES_ONE, 8'h10);
        wr(`IDX_INTERRUPT_CONTROL, 8'hc0);
        wr(`IDX_TRANSMIT_STATUS_CONTROL, 8'h30);
        rd_chk(`IDX_TRANSMIT_STATUS_CONTROL, 8'h32);
        wr(`IDX_TRANSMIT_HOLDING, 8'ha4);
        wait_words(1);
        `CHK(data_pin_oe_n, 1'b0)
        `CHK(last_word, 9'h0a4)
        wait_hi(shift_register_empty);
        `CHK(shift_register_empty, 1'b1)
        `CHK(interrupt_vector_request, 1'b1)
        `CHK(wake_request, 1'b0)
    endtask : t_single
    task automatic t_sleep();
        sleep_mode <= 1'b1;
        wr(`IDX_TRANSMIT_HOLDING, 8'h3c);
        wr(`IDX_TRANSMIT_HOLDING, 8'h96);
        rd_chk(`IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
        `CHK(wake_request, 1'b0)
        `CHK(words, 1)
        wait_words(2);
        `CHK(last_word, 9'h03c)
        wait_hi(wake_request);
        `CHK(wake_request, 1'b1)
        `CHK(interrupt_vector_request, 1'b1)
        rd_chk(`IDX_PERIPHERAL_FLAGS_ONE, 8'h10);
        wait_words(3);
        `CHK(last_word, 9'h096)
        sleep_mode <= 1'b0;
        wait_hi(shift_register_empty);
    endtask : t_sleep
    task automatic t_nine();
        wr(`IDX_TRANSMIT_STATUS_CONTROL, 8'h10);
        run <= 1'b0;
        wr(`IDX_BAUD_CONTROL, 8'h10);
        repeat (12) @(posedge core_clk);
        invert <= 1'b1;
        nine <= 1'b1;
        run <= 1'b1;
        wr(`IDX_TRANSMIT_STATUS_CONTROL, 8'h71);
        wr(`IDX_TRANSMIT_HOLDING, 8'h52);
        wait_words(4);
        `CHK(last_word, 9'h152)
        wait_hi(shift_register_empty);
    endtask : t_nine
    task automatic t_master();
        wr(`IDX_TRANSMIT_STATUS_CONTROL, 8'hb0);
        wr(`IDX_TRANSMIT_HOLDING, 8'h18);
        // Nothing may leave, so only a fixed quiet period can show it.
        repeat (200) @(posedge core_clk);
        `CHK(words, 4)
        `CHK(data_pin_oe_n, 1'b1)
    endtask : t_master
    initial begin
        // The link side synchronises reset, so it must see link edges.
        repeat (30) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_single();
        t_sleep();
        t_nine();
        t_master();
        conclude();
    end
endmodule : tb_sync_slave_serial_tx
bind sync_slave_serial_tx sst_tx_props i_props (.core_clk, .rst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .sleep_mode, .shift_clock_pin,
    .data_pin_out, .data_pin_oe_n, .shift_register_empty, .wake_request,
    .interrupt_vector_request);
